// >>> mfis_map.svh
// constants of the multifunction input scaler: offsets, fields, resets, times
// assumes sample codes of 0.01 % of full scale (1 mV or 2 uA per code)
// Summary of operation
// - mode 1, 2 and 5 read the input as 0-10 V, 0-20 mA or 4-20 mA, fixed.
// - mode 3 is a digital level active at 0 V, mode 4 active at 24 V; 3 at reset.
// - modes 6 and 7 map voltage or current through the two-point line.
// - in current modes an input above its maximum raises a sticky fault.
// - fixed voltage mode has zero at 0.2 V and full scale at 9.8 V.
// - fixed 0-20 mA mode has zero at 0.4 mA and full scale at 19.6 mA.
// - fixed 4-20 mA mode has zero at 4.4 mA and full scale at 19.6 mA.
// - point abscissae are percent of 10 V or 20 mA, ordinates percent of max.
// - four sets of two points, X 0..100 %, Y -100..100 %, reset (2,0),(98,100).
// - reference is Y1 + (Y2 - Y1) * (X - X1) / (X2 - X1).
// - direction follows the direction pins or the sign of the reference.
// - with monitoring on, an input below 1 V or 2 mA warns, stricter faults.
// - the reference passes a low pass of 0 ms (bypass) to 5000 ms.
`ifndef MFIS_MAP_SVH
`define MFIS_MAP_SVH

// register word addresses
`define MFIS_ADR_MODE      6'h00
`define MFIS_ADR_CTRL      6'h01
`define MFIS_ADR_STAT      6'h02
`define MFIS_ADR_REF       6'h03
`define MFIS_ADR_RAW       6'h04
`define MFIS_ADR_PTS       6'h10

// control fields
`define MFIS_CTRL_SET_LSB  0
`define MFIS_CTRL_DIR_BIT  2
`define MFIS_CTRL_MON_LSB  4
`define MFIS_CTRL_FLT_LSB  8

// status fields
`define MFIS_STAT_OVER     0
`define MFIS_STAT_WARN     1
`define MFIS_STAT_FAULT    2
`define MFIS_STAT_DIG      3
`define MFIS_STAT_REV      4

// reset values
`define MFIS_MODE_RESET    3'h3
`define MFIS_X1_RESET      16'h00c8
`define MFIS_Y1_RESET      16'h0000
`define MFIS_X2_RESET      16'h2648
`define MFIS_Y2_RESET      16'h2710

// characteristic figures, in sample codes and 0.01 % units
`define MFIS_FULL          16'h2710
`define MFIS_ZERO_V        16'h00c8
`define MFIS_SPAN_V        16'h2580
`define MFIS_ZERO_I        16'h00c8
`define MFIS_SPAN_I        16'h2580
`define MFIS_ZERO_I4       16'h0898
`define MFIS_SPAN_I4       16'h1db0
`define MFIS_UNDER         16'h03e8
`define MFIS_FAULT_CODE    16'h057f

// filter timing
`define MFIS_CLK_HZ        100000000
`define MFIS_MS_PER_S      1000
`define MFIS_TAU_SHIFT     4
`define MFIS_TAU_STEP_MS   1000
`define MFIS_DIV_STEPS     6'h20

`endif

// >>> mfis_pkg.sv
// types shared by the multifunction input scaler
// assumes nothing beyond a SystemVerilog tool
`default_nettype none
package mfis_pkg;
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CALC = 3'b010,
		ST_LOAD = 3'b100
	} mfis_state_e;
	// input modes
	typedef enum logic [2:0] {
		MODE_V_FIX  = 3'h1,
		MODE_I_FIX  = 3'h2,
		MODE_D_NPN  = 3'h3,
		MODE_D_PNP  = 3'h4,
		MODE_I4_FIX = 3'h5,
		MODE_V_CHR  = 3'h6,
		MODE_I_CHR  = 3'h7
	} mfis_mode_e;
endpackage
`default_nettype wire

// >>> mfis_div.sv
// serial signed divider for the characteristic slope
// assumes start only while idle; answer 33 cycles after start
`default_nettype none
`include "mfis_map.svh"
module mfis_div (
	// clock and reset
	input  wire logic               sys_clk_in,
	input  wire logic               rstn_in,
	// request
	input  wire logic               start_in,
	input  wire logic signed [31:0] num_in,
	input  wire logic signed [16:0] den_in,
	// answer
	output logic                    done_out,
	output logic signed [31:0]      quot_out
);
	logic        [32:0] rem;
	logic        [31:0] quo;
	logic        [16:0] dmag;
	logic               neg;
	logic        [5:0]  cnt;
	logic        [32:0] shifted;
	logic        [32:0] trial;
	logic        [31:0] next_quo;

	// one restoring step per cycle, quotient truncates toward zero
	always_comb begin
		shifted  = {rem[31:0], quo[31]};
		trial    = shifted - {16'h0000, dmag};
		next_quo = {quo[30:0], ~trial[32]};
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rem      <= 33'h0;
			quo      <= 32'h0;
			dmag     <= 17'h0;
			neg      <= 1'b0;
			cnt      <= 6'h0;
			done_out <= 1'b0;
			quot_out <= 32'sh0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				rem  <= 33'h0;
				quo  <= num_in[31] ? 32'(-num_in) : 32'(num_in);
				dmag <= den_in[16] ? 17'(-den_in) : 17'(den_in);
				neg  <= num_in[31] ^ den_in[16];
				cnt  <= `MFIS_DIV_STEPS;
			end else if (cnt != 6'h0) begin
				rem <= trial[32] ? shifted : trial;
				quo <= next_quo;
				cnt <= cnt - 6'h1;
				if (cnt == 6'h1) begin
					done_out <= 1'b1;
					quot_out <= neg ? -$signed(next_quo) : $signed(next_quo);
				end
			end
		end
	end

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	chk_div_latency: assert property (start_in |-> ##33 done_out)
		else $error("divider answer not 33 cycles after start");
endmodule // mfis_div
`default_nettype wire

// >>> mfis_top.sv
// multifunction input scaler: mode select, characteristic, filter, monitors
// assumes an ADC word and comparator level on pins, a same-clock register port
`default_nettype none
`include "mfis_map.svh"
module mfis_top #(
	parameter int FILT_CYC_PER_MS =
		(`MFIS_CLK_HZ / `MFIS_MS_PER_S) >> `MFIS_TAU_SHIFT
) (
	// clock and reset
	input  wire logic               sys_clk_in,
	input  wire logic               rstn_in,
	// register port
	input  wire logic [5:0]         reg_addr_in,
	input  wire logic [31:0]        reg_wdata_in,
	input  wire logic               reg_wr_in,
	input  wire logic               reg_rd_in,
	output logic      [31:0]        reg_rdata_out,
	// terminal pins
	input  wire logic [13:0]        sample_in,
	input  wire logic               term_level_in,
	input  wire logic               dir_rev_in,
	// reference channel
	output logic signed [15:0]      ref_out,
	output logic                    reverse_out,
	output logic                    digital_view_out,
	// monitoring
	output logic                    over_fault_out,
	output logic      [15:0]        fault_code_out,
	output logic                    under_warn_out,
	output logic                    under_fault_out
);
	localparam logic signed [16:0] FULL = 17'(`MFIS_FULL);

	logic [13:0]              samp_m, samp_s, samp_t, samp_q;
	logic                     lvl_m, lvl_s, rev_m, rev_s;
	logic [2:0]               mode;
	logic [1:0]               set_sel;
	logic                     dir_sign;
	logic [1:0]               mon;
	logic [3:0]               flt_sel;
	logic signed [15:0]       pts [16];
	logic                     over_flag;
	logic                     ovr_clr;
	logic signed [15:0]       raw;
	logic signed [19:0]       acc;
	logic [31:0]              flt_cnt;
	logic [31:0]              flt_lim;
	mfis_pkg::mfis_state_e    state;
	logic signed [15:0]       lat_y1;
	logic                     lat_uni;
	logic                     analog;
	logic                     is_cur;
	logic                     uni;
	logic signed [16:0]       x, cx1, cy1, cdx, cdy;
	logic signed [33:0]       prod;
	logic                     div_go, div_done;
	logic signed [31:0]       quot;
	logic                     low_in;

	// pins cross from the converter domain through two flops each
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			samp_m <= 14'h0;
			samp_s <= 14'h0;
			samp_t <= 14'h0;
			samp_q <= 14'h0;
			lvl_m  <= 1'b0;
			lvl_s  <= 1'b0;
			rev_m  <= 1'b0;
			rev_s  <= 1'b0;
		end else begin
			samp_m <= sample_in;
			samp_s <= samp_m;
			// a word is taken only once it held still, so a converter
			// update caught between bits never mixes two codes
			samp_t <= samp_s;
			if (samp_s == samp_t)
				samp_q <= samp_s;
			lvl_m  <= term_level_in;
			lvl_s  <= lvl_m;
			rev_m  <= dir_rev_in;
			rev_s  <= rev_m;
		end
	end

	// mode and control written by software
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mode     <= `MFIS_MODE_RESET;
			set_sel  <= 2'h0;
			dir_sign <= 1'b0;
			mon      <= 2'h0;
			flt_sel  <= 4'h0;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `MFIS_ADR_MODE)
				mode <= reg_wdata_in[2:0];
			if (reg_addr_in == `MFIS_ADR_CTRL) begin
				set_sel  <= reg_wdata_in[`MFIS_CTRL_SET_LSB +: 2];
				dir_sign <= reg_wdata_in[`MFIS_CTRL_DIR_BIT];
				mon      <= reg_wdata_in[`MFIS_CTRL_MON_LSB +: 2];
				flt_sel  <= reg_wdata_in[`MFIS_CTRL_FLT_LSB +: 4];
			end
		end
	end

	// point store; writes saturate to the legal range of each coordinate
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < 16; i++) begin
				case (i % 4)
					0:       pts[i] <= `MFIS_X1_RESET;
					1:       pts[i] <= `MFIS_Y1_RESET;
					2:       pts[i] <= `MFIS_X2_RESET;
					default: pts[i] <= `MFIS_Y2_RESET;
				endcase
			end
		end else if (reg_wr_in && reg_addr_in[5:4] == `MFIS_ADR_PTS >> 4)
			begin
			if ($signed(reg_wdata_in) > $signed(32'(FULL)))
				pts[reg_addr_in[3:0]] <= `MFIS_FULL;
			else if (!reg_addr_in[0] && reg_wdata_in[31])
				pts[reg_addr_in[3:0]] <= 16'h0000;
			else if ($signed(reg_wdata_in) < -$signed(32'(FULL)))
				pts[reg_addr_in[3:0]] <= -16'(`MFIS_FULL);
			else
				pts[reg_addr_in[3:0]] <= reg_wdata_in[15:0];
		end
	end

	// operating point of the line for the present mode
	always_comb begin
		x      = 17'({3'h0, samp_q});
		analog = 1'b1;
		is_cur = 1'b0;
		uni    = 1'b1;
		cx1    = 17'(`MFIS_ZERO_V);
		cy1    = 17'sh0;
		cdx    = 17'(`MFIS_SPAN_V);
		cdy    = FULL;
		case (mode)
			mfis_pkg::MODE_V_FIX: begin
				cx1 = 17'(`MFIS_ZERO_V);
				cdx = 17'(`MFIS_SPAN_V);
			end
			mfis_pkg::MODE_I_FIX: begin
				is_cur = 1'b1;
				cx1    = 17'(`MFIS_ZERO_I);
				cdx    = 17'(`MFIS_SPAN_I);
			end
			mfis_pkg::MODE_I4_FIX: begin
				is_cur = 1'b1;
				cx1    = 17'(`MFIS_ZERO_I4);
				cdx    = 17'(`MFIS_SPAN_I4);
			end
			mfis_pkg::MODE_V_CHR, mfis_pkg::MODE_I_CHR: begin
				// X in sample codes equals percent of 10 V or 20 mA
				is_cur = mode[0];
				uni    = 1'b0;
				cx1    = 17'(pts[{set_sel, 2'h0}]);
				cy1    = 17'(pts[{set_sel, 2'h1}]);
				cdx    = 17'(pts[{set_sel, 2'h2}]) - cx1;
				cdy    = 17'(pts[{set_sel, 2'h3}]) - cy1;
			end
			default: analog = 1'b0;
		endcase
		prod = cdy * (x - cx1);
	end

	assign div_go = state == mfis_pkg::ST_IDLE && analog && cdx != 17'sh0;

	// numerator fits 32 bits: |dy| <= 20000 and |x - x1| < 2^15
	mfis_div u_div (
		.sys_clk_in (sys_clk_in),
		.rstn_in    (rstn_in),
		.start_in   (div_go),
		.num_in     (prod[31:0]),
		.den_in     (cdx),
		.done_out   (div_done),
		.quot_out   (quot)
	);

	// sequencer: one new reference per division, about every 35 cycles
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state   <= mfis_pkg::ST_IDLE;
			raw     <= 16'sh0;
			lat_y1  <= 16'sh0;
			lat_uni <= 1'b1;
		end else begin
			case (state)
				mfis_pkg::ST_IDLE: begin
					lat_y1  <= cy1[15:0];
					lat_uni <= uni;
					if (!analog)
						raw <= 16'sh0;
					else if (cdx == 17'sh0)
						raw <= cy1[15:0];
					else
						state <= mfis_pkg::ST_CALC;
				end
				mfis_pkg::ST_CALC:
					if (div_done)
						state <= mfis_pkg::ST_LOAD;
				mfis_pkg::ST_LOAD: begin
					// fixed lines stop at zero, user lines at -100 %
					if (33'(lat_y1) + 33'(quot) > 33'(FULL))
						raw <= `MFIS_FULL;
					else if (lat_uni && 33'(lat_y1) + 33'(quot) < 33'sh0)
						raw <= 16'sh0;
					else if (33'(lat_y1) + 33'(quot) < -33'(FULL))
						raw <= -16'(`MFIS_FULL);
					else
						raw <= 16'(lat_y1 + quot[15:0]);
					state <= mfis_pkg::ST_IDLE;
				end
				default: state <= mfis_pkg::ST_IDLE;
			endcase
		end
	end

	// filter period: 1/16 of the time constant, exact for every step
	always_comb begin
		if (flt_sel < 4'ha)
			flt_lim = 32'(FILT_CYC_PER_MS) << flt_sel;
		else if (flt_sel < 4'hf)
			flt_lim = 32'(FILT_CYC_PER_MS) * 32'(`MFIS_TAU_STEP_MS)
				* 32'(flt_sel - 4'h9);
		else
			flt_lim = 32'(FILT_CYC_PER_MS) * 32'(`MFIS_TAU_STEP_MS) * 32'h5;
	end

	// first order low pass; acc holds sixteen times the output
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			acc     <= 20'sh0;
			flt_cnt <= 32'h0;
		end else if (flt_sel == 4'h0) begin
			acc     <= {raw, 4'h0};
			flt_cnt <= 32'h0;
		end else if (flt_cnt + 32'h1 >= flt_lim) begin
			acc     <= acc + 20'(raw) - (acc >>> `MFIS_TAU_SHIFT);
			flt_cnt <= 32'h0;
		end else
			flt_cnt <= flt_cnt + 32'h1;
	end

	assign ref_out = acc[19:4];

	// direction from the pin or from the sign of the filtered reference
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reverse_out      <= 1'b0;
			digital_view_out <= 1'b0;
		end else begin
			reverse_out <= dir_sign ? ref_out[15] : rev_s;
			digital_view_out <= (mode == mfis_pkg::MODE_D_NPN && !lvl_s) ||
				(mode == mfis_pkg::MODE_D_PNP && lvl_s);
		end
	end

	// over-range is sticky; a new excess beats a clear in the same cycle
	assign ovr_clr = reg_wr_in && reg_addr_in == `MFIS_ADR_STAT &&
		reg_wdata_in[`MFIS_STAT_OVER];
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			over_flag <= 1'b0;
		else if (analog && is_cur && x > FULL)
			over_flag <= 1'b1;
		else if (ovr_clr)
			over_flag <= 1'b0;
	end

	assign over_fault_out = over_flag;
	assign fault_code_out = over_flag ? `MFIS_FAULT_CODE : 16'h0000;
	assign low_in = analog && x < 17'(`MFIS_UNDER);

	// undervoltage and undercurrent monitor, active only while mon is nonzero
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			under_warn_out  <= 1'b0;
			under_fault_out <= 1'b0;
		end else begin
			under_warn_out  <= mon != 2'h0 && low_in;
			under_fault_out <= mon[1] && low_in;
		end
	end

	// read data one cycle after the strobe; unmapped words read zero
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			reg_rdata_out <= 32'h0;
		else if (reg_rd_in) begin
			reg_rdata_out <= 32'h0;
			if (reg_addr_in[5:4] == `MFIS_ADR_PTS >> 4)
				reg_rdata_out <= 32'(pts[reg_addr_in[3:0]]);
			else
				case (reg_addr_in)
					`MFIS_ADR_MODE: reg_rdata_out <= {29'h0, mode};
					`MFIS_ADR_CTRL: reg_rdata_out <= {20'h0, flt_sel,
						2'h0, mon, 1'b0, dir_sign, set_sel};
					`MFIS_ADR_STAT: reg_rdata_out <= {27'h0, reverse_out,
						digital_view_out, under_fault_out, under_warn_out,
						over_flag};
					`MFIS_ADR_REF:  reg_rdata_out <= 32'(ref_out);
					`MFIS_ADR_RAW:  reg_rdata_out <= 32'(raw);
					default:        reg_rdata_out <= 32'h0;
				endcase
		end
	end

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	chk_npn_view_low: assert property (
		mode == mfis_pkg::MODE_D_NPN |=> digital_view_out == !$past(lvl_s))
		else $error("npn view does not follow inverted level");
	chk_pnp_view_high: assert property (
		mode == mfis_pkg::MODE_D_PNP |=> digital_view_out == $past(lvl_s))
		else $error("pnp view does not follow level");
	chk_digital_ref_zero: assert property (
		!analog && state == mfis_pkg::ST_IDLE |=> raw == 16'sh0)
		else $error("digital mode left a reference");
	chk_over_set: assert property (
		analog && is_cur && x > FULL |=> over_fault_out ##0
		fault_code_out == `MFIS_FAULT_CODE)
		else $error("current excess not flagged");
	chk_over_sticky: assert property (
		over_flag && !ovr_clr |=> over_flag)
		else $error("over-range flag dropped without clear");
	chk_ref_bounds: assert property (
		raw <= FULL && raw >= -FULL)
		else $error("reference outside +-100 percent");
	chk_equal_absc: assert property (
		state == mfis_pkg::ST_IDLE && analog && cdx == 17'sh0
		|=> raw == $past(cy1))
		else $error("equal abscissae did not give Y1");
	chk_calc_bound: assert property (
		state == mfis_pkg::ST_CALC |-> ##[1:34] state == mfis_pkg::ST_LOAD)
		else $error("characteristic result late");
	chk_filter_bypass: assert property (
		flt_sel == 4'h0 |=> ref_out == $past(raw))
		else $error("bypass filter delayed the reference");
	chk_under_warn: assert property (
		mon != 2'h0 && low_in |=> under_warn_out)
		else $error("low input not warned");
endmodule // mfis_top
`default_nettype wire

// >>> mfis_field.sv
// field signal source model for the second multifunction input terminal
// assumes the bench sets its targets just after a rising clock edge
`default_nettype none
module mfis_field (
	// clock
	input  wire logic        sys_clk_in,
	// targets from the bench
	input  wire logic [13:0] code_in,
	input  wire logic        lvl_in,
	input  wire logic        rev_in,
	input  wire logic        slow_in,
	// terminal pins
	output logic      [13:0] sample_out,
	output logic             term_level_out,
	output logic             dir_rev_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic step = 1'b0;

	// pins start defined so the synchronizers never see unknowns
	initial begin
		sample_out = 14'h0000;
		term_level_out = 1'b0;
		dir_rev_out = 1'b0;
	end

	// a slow source slews 128 codes every second cycle; each mid value
	// holds long enough for the scaler's stability check to take it
	always @(posedge sys_clk_in) begin
		term_level_out <= lvl_in;
		dir_rev_out <= rev_in;
		step <= !step;
		if (!slow_in)
			sample_out <= code_in;
		else if (step) begin
			if (sample_out + 14'h0080 < code_in)
				sample_out <= sample_out + 14'h0080;
			else if (sample_out > code_in + 14'h0080)
				sample_out <= sample_out - 14'h0080;
			else
				sample_out <= code_in;
		end
	end
endmodule // mfis_field
`default_nettype wire

// >>> mfis_tb.sv
// self-checking bench of the multifunction input scaler
// assumes the design files and the field source model are compiled first
`default_nettype none
`include "mfis_map.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
	miscompares++; \
	$display("CHECK FAILED %s exp %0d got %0d", nm, ex, got); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic               sys_clk = 1'b0;
	logic               rstn = 1'b0;
	logic        [5:0]  addr = 6'h00;
	logic        [31:0] wdata = 32'h0000_0000;
	logic               wr_s = 1'b0;
	logic               rd_s = 1'b0;
	logic        [13:0] code = 14'h0000;
	logic               lvl = 1'b0;
	logic               rev = 1'b0;
	logic               slow = 1'b0;
	wire         [31:0] rdata;
	wire         [13:0] sample;
	wire                term;
	wire                dir_rev;
	wire signed  [15:0] ref_v;
	wire                rev_o;
	wire                dview;
	wire                over;
	wire         [15:0] fcode;
	wire                uwarn;
	wire                ufault;
	int                 tests_run = 0;
	int                 miscompares = 0;

	always #5 sys_clk = ~sys_clk;

	// filter step shortened to tau_ms cycles
	mfis_top #(.FILT_CYC_PER_MS(1)) mfis_top_inst (
		.sys_clk_in(sys_clk), .rstn_in(rstn), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
		.reg_rdata_out(rdata), .sample_in(sample), .term_level_in(term),
		.dir_rev_in(dir_rev), .ref_out(ref_v), .reverse_out(rev_o),
		.digital_view_out(dview), .over_fault_out(over),
		.fault_code_out(fcode), .under_warn_out(uwarn),
		.under_fault_out(ufault));

	mfis_field mfis_field_inst (
		.sys_clk_in(sys_clk), .code_in(code), .lvl_in(lvl), .rev_in(rev),
		.slow_in(slow), .sample_out(sample), .term_level_out(term),
		.dir_rev_out(dir_rev));

	task automatic stop_test();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge sys_clk);
		wr_s <= 1'b0;
	endtask

	// read data stand from the cycle after the read strobe until the next read
	task automatic rd_chk(input string nm, input logic [5:0] a, input int ex);
		@(posedge sys_clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge sys_clk);
		rd_s <= 1'b0;
		#1;
		`CHK(nm, ex, rdata)
	endtask

	// bounded wait: the divide pass plus slewing stays well under 400
	task automatic ref_is(input string nm, input int ex);
		int n;
		n = 0;
		while (ref_v !== 16'(ex) && n < 400) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		`CHK(nm, ex, ref_v)
	endtask

	task automatic pts(input int s, input int x1, y1, x2, y2);
		wr(`MFIS_ADR_PTS + 6'(s * 4), x1);
		wr(`MFIS_ADR_PTS + 6'(s * 4 + 1), y1);
		wr(`MFIS_ADR_PTS + 6'(s * 4 + 2), x2);
		wr(`MFIS_ADR_PTS + 6'(s * 4 + 3), y2);
	endtask

	function automatic int fx(int z, int sp, int s);
		int v;
		v = (s - z) * 10000 / sp;
		return v < 0 ? 0 : (v > 10000 ? 10000 : v);
	endfunction

	function automatic int ch(int x1, y1, x2, y2, s);
		int v;
		v = (x1 == x2) ? y1 : y1 + (y2 - y1) * (s - x1) / (x2 - x1);
		return v < -10000 ? -10000 : (v > 10000 ? 10000 : v);
	endfunction

	task automatic t_reset();
		rd_chk("mode", `MFIS_ADR_MODE, 3);
		for (int s = 0; s < 4; s++) begin
			rd_chk("x1", `MFIS_ADR_PTS + 6'(s * 4), 200);
			rd_chk("y1", `MFIS_ADR_PTS + 6'(s * 4 + 1), 0);
			rd_chk("x2", `MFIS_ADR_PTS + 6'(s * 4 + 2), 9800);
			rd_chk("y2", `MFIS_ADR_PTS + 6'(s * 4 + 3), 10000);
		end
		rd_chk("unmapped", 6'h3f, 0);
		`CHK("npn view low", 1'b1, dview)
	endtask

	task automatic t_digital();
		lvl <= 1'b1;
		repeat (5) @(posedge sys_clk);
		`CHK("npn view high", 1'b0, dview)
		wr(`MFIS_ADR_MODE, 32'h4);
		repeat (5) @(posedge sys_clk);
		`CHK("pnp view high", 1'b1, dview)
		lvl <= 1'b0;
		repeat (5) @(posedge sys_clk);
		`CHK("pnp view low", 1'b0, dview)
		lvl <= 1'b1;
		wr(`MFIS_ADR_MODE, 32'h0);
		repeat (5) @(posedge sys_clk);
		`CHK("mode off view", 1'b0, dview)
	endtask

	task automatic t_fixed();
		int md[3] = '{1, 2, 5};
		int z[3] = '{200, 200, 2200};
		int sp[3] = '{9600, 9600, 7600};
		int sm[4] = '{5000, 9800, 100, 5999};
		for (int i = 0; i < 3; i++) begin
			wr(`MFIS_ADR_MODE, md[i]);
			slow <= (i == 1);
			for (int j = 0; j < 4; j++) begin
				code <= sm[j];
				ref_is("fixed ref", fx(z[i], sp[i], sm[j]));
				rd_chk("raw", `MFIS_ADR_RAW, fx(z[i], sp[i], sm[j]));
			end
			`CHK("analog view", 1'b0, dview)
		end
		slow <= 1'b0;
	endtask

	task automatic t_chr();
		pts(1, 1000, 10000, 9000, -10000);
		wr(`MFIS_ADR_CTRL, 32'h5);
		wr(`MFIS_ADR_MODE, 32'h6);
		code <= 14'd3000;
		ref_is("chr fall", ch(1000, 10000, 9000, -10000, 3000));
		// direction follows the reference one cycle later
		@(posedge sys_clk);
		#1;
		`CHK("fwd", 1'b0, rev_o)
		code <= 14'd7000;
		ref_is("chr neg", ch(1000, 10000, 9000, -10000, 7000));
		@(posedge sys_clk);
		#1;
		`CHK("rev sign", 1'b1, rev_o)
		code <= 14'd0;
		ref_is("chr sat", 10000);
		wr(`MFIS_ADR_MODE, 32'h7);
		code <= 14'd7000;
		ref_is("chr cur", -5000);
		pts(1, 5000, -3000, 5000, 8000);
		code <= 14'd2000;
		ref_is("chr flat", -3000);
		wr(`MFIS_ADR_PTS + 6'h0b, 32'd20000);
		rd_chk("y2 clip", `MFIS_ADR_PTS + 6'h0b, 10000);
		wr(`MFIS_ADR_CTRL, 32'h0);
		wr(`MFIS_ADR_MODE, 32'h6);
		code <= 14'd5000;
		ref_is("set0 dflt", ch(200, 0, 9800, 10000, 5000));
		rd_chk("ref reg", `MFIS_ADR_REF, 5000);
		rev <= 1'b1;
		repeat (5) @(posedge sys_clk);
		`CHK("rev pin", 1'b1, rev_o)
		rev <= 1'b0;
		repeat (5) @(posedge sys_clk);
		`CHK("fwd pin", 1'b0, rev_o)
	endtask

	task automatic t_over();
		int md[3] = '{2, 5, 7};
		for (int i = 0; i < 3; i++) begin
			wr(`MFIS_ADR_MODE, md[i]);
			code <= 14'd10000;
			repeat (8) @(posedge sys_clk);
			`CHK("at max", 1'b0, over)
			code <= 14'd10001;
			repeat (8) @(posedge sys_clk);
			`CHK("over", 1'b1, over)
			`CHK("code", 16'h057f, fcode)
			code <= 14'd5000;
			rd_chk("stat", `MFIS_ADR_STAT, 1);
			// let the lower sample settle, else the excess beats the clear
			repeat (4) @(posedge sys_clk);
			wr(`MFIS_ADR_STAT, 32'h1);
			repeat (2) @(posedge sys_clk);
			`CHK("cleared", 1'b0, over)
			`CHK("code off", 16'h0000, fcode)
		end
		wr(`MFIS_ADR_MODE, 32'h1);
		code <= 14'd12000;
		repeat (8) @(posedge sys_clk);
		`CHK("volt no over", 1'b0, over)
	endtask

	task automatic t_under();
		int ctl[4] = '{32'h10, 32'h20, 32'h30, 32'h0};
		code <= 14'd999;
		for (int i = 0; i < 4; i++) begin
			wr(`MFIS_ADR_CTRL, ctl[i]);
			repeat (8) @(posedge sys_clk);
			`CHK("warn", (i < 3), uwarn)
			`CHK("ufault", (i == 1 || i == 2), ufault)
		end
		wr(`MFIS_ADR_CTRL, 32'h30);
		code <= 14'd1000;
		repeat (8) @(posedge sys_clk);
		`CHK("warn edge", 1'b0, uwarn)
		wr(`MFIS_ADR_MODE, 32'h2);
		code <= 14'd500;
		repeat (8) @(posedge sys_clk);
		`CHK("cur fault", 1'b1, ufault)
		wr(`MFIS_ADR_CTRL, 32'h0);
	endtask

	task automatic t_filter();
		wr(`MFIS_ADR_MODE, 32'h1);
		code <= 14'd200;
		ref_is("filt base", 0);
		wr(`MFIS_ADR_CTRL, 32'h400);
		code <= 14'd5000;
		repeat (120) @(posedge sys_clk);
		`CHK("filt mid", 1'b1, (ref_v > 16'sd0 && ref_v < 16'sd5000))
		repeat (6000) @(posedge sys_clk);
		`CHK("filt end", 1'b1, (ref_v > 16'sd4968 && ref_v < 16'sd5032))
		wr(`MFIS_ADR_CTRL, 32'h0);
	endtask

	// tests together need well under 20000 cycles
	initial begin
		repeat (40000) @(posedge sys_clk);
		miscompares++;
		stop_test();
	end

	initial begin
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
		t_reset();
		t_digital();
		t_fixed();
		t_chr();
		t_over();
		t_under();
		t_filter();
		stop_test();
	end
endmodule // tb
`default_nettype wire
